/* File: verilog/aic_pkg.sv */
// aic_pkg: constants shared by the annunciator icon controller files
// assumes a 10 MHz core clock; all times below are converted to cycles here
package aic_pkg;
   // =====================================================
   // geometry
   localparam int ICON_CNT = 24;
   localparam int SINK_CNT = 2;
   localparam int ICON_IDX_W = 5;
   // icon positions of the direct-wired lamps
   localparam int ICON_LEFT_TURN = 0;
   localparam int ICON_RIGHT_TURN = 1;
   localparam int ICON_HIGH_BEAM = 2;
   // =====================================================
   // timing, in own units then cycles
   localparam longint CLK_HZ = 10000000;
   localparam longint LOSS_TIME_S = 45;
   localparam longint LOSS_CYC = LOSS_TIME_S * CLK_HZ;
   localparam longint CHECK_TIME_S = 3;
   localparam longint CHECK_CYC = CHECK_TIME_S * CLK_HZ;
   localparam longint FLASH_HALF_MS = 50;
   localparam longint FLASH_HALF_CYC = FLASH_HALF_MS * CLK_HZ / 1000;
   localparam longint FLASH_COUNT = 6;
   localparam longint CHASE_STEP_MS = 100;
   localparam longint CHASE_STEP_CYC = CHASE_STEP_MS * CLK_HZ / 1000;
   localparam int TMR_W = 32;
   // =====================================================
   // reset values
   localparam logic [ICON_CNT-1:0] ICON_RST = 24'h000000;
   localparam logic [SINK_CNT-1:0] SINK_N_RST = 2'h3;
   // =====================================================
   // display sequencer states
   typedef enum logic [2:0] {
      ST_FLASH,
      ST_CHECK,
      ST_RUN,
      ST_CHASE
   } aic_state_t;
endpackage

/* File: verilog/aic_sync.sv */
// aic_sync: two-flop synchroniser bank for pin inputs
// assumes inputs are asynchronous levels; first stage feeds only the second
`timescale 1ns/1ps
module aic_sync #(
   parameter int WIDTH = 3
) (
   input wire logic core_clk_i,
   input wire logic nrst_i,
   input wire logic ce_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] meta_next;
   logic [WIDTH-1:0] sync_reg;
   logic [WIDTH-1:0] sync_next;

   // =====================================================
   // synchroniser stages
   always_comb begin
      meta_next = ce_i ? async_i : meta_reg;
      sync_next = ce_i ? meta_reg : sync_reg;
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         meta_reg <= '0;
         sync_reg <= '0;
      end else begin
         meta_reg <= meta_next;
         sync_reg <= sync_next;
      end
   end

   assign sync_o = sync_reg;
endmodule

/* File: verilog/aic_top.sv */
// aic_top: annunciator icon controller, 24 icons, two sinking outputs
// assumes a decoded instrument_display_bus word port from on-chip logic,
// nrst_i is the ignition power-on reset, lamp inputs are raw pins
// Function
// - 24 icons; icons 3 to 23 switched on or off by instrument bus commands.
// - two active-low sinking outputs; asserted pulls to ground, else released.
// - sinking outputs change only on bus commands from central_data_computer.
// - in run mode, no bus data over 45 seconds starts a chase pattern on the icons.
// - turn and high-beam icons follow their wired inputs at all times.
// - once ignition is seen after reset, flash icons 3 to 23 rapidly as self-test first.
// - then icons 3 to 23 on three seconds, then bus-commanded states.
`timescale 1ns/1ps
module aic_top
   import aic_pkg::*;
#(
   parameter longint LOSS_CYCLES = aic_pkg::LOSS_CYC,
   parameter longint CHECK_CYCLES = aic_pkg::CHECK_CYC,
   parameter longint FLASH_CYCLES = aic_pkg::FLASH_HALF_CYC,
   parameter longint STEP_CYCLES = aic_pkg::CHASE_STEP_CYC
) (
   input wire logic core_clk_i,
   input wire logic nrst_i,
   input wire logic ce_i,
   input wire logic bus_valid_i,
   input wire logic [aic_pkg::ICON_CNT-1:0] bus_icons_i,
   input wire logic [aic_pkg::SINK_CNT-1:0] bus_sink_i,
   input wire logic left_turn_i,
   input wire logic right_turn_i,
   input wire logic high_beam_i,
   input wire logic ignition_i,
   output logic [aic_pkg::ICON_CNT-1:0] icon_o,
   output logic [aic_pkg::SINK_CNT-1:0] sink_n_o,
   output logic comm_lost_o
);
   import aic_pkg::*;

   localparam logic [TMR_W-1:0] LOSS_LIM = TMR_W'(LOSS_CYCLES - 1);
   localparam logic [TMR_W-1:0] CHECK_LIM = TMR_W'(CHECK_CYCLES - 1);
   // flash and chase timing are parameters so a short run can reach every mode
   localparam logic [TMR_W-1:0] FLASH_LIM = TMR_W'(FLASH_CYCLES - 1);
   localparam logic [TMR_W-1:0] STEP_LIM = TMR_W'(STEP_CYCLES - 1);
   localparam logic [3:0] FLASH_EDGES = 4'(2 * FLASH_COUNT - 1);

   logic [2:0] lamp_sync;
   logic ign_sync;
   logic [3:0] unused_sync;

   // =====================================================
   // pin synchronisers for lamps and ignition
   aic_sync #(.WIDTH(4)) u_sync (
      .core_clk_i(core_clk_i),
      .nrst_i(nrst_i),
      .ce_i(ce_i),
      .async_i({ignition_i, high_beam_i, right_turn_i, left_turn_i}),
      .sync_o(unused_sync)
   );
   assign lamp_sync = unused_sync[2:0];
   assign ign_sync = unused_sync[3];

   aic_state_t state_reg, state_next;
   logic [TMR_W-1:0] tmr_reg, tmr_next;
   logic [TMR_W-1:0] loss_reg, loss_next;
   logic [3:0] flash_reg, flash_next;
   logic [ICON_IDX_W-1:0] chase_reg, chase_next;
   logic [ICON_CNT-1:0] cmd_reg, cmd_next;
   logic [SINK_CNT-1:0] sink_n_reg, sink_n_next;
   logic [ICON_CNT-1:0] icon_reg, icon_next;
   logic ign_seen_reg, ign_seen_next;
   logic [ICON_CNT-1:0] base;

   // =====================================================
   // bus command latch and sinking outputs
   always_comb begin
      cmd_next = cmd_reg;
      sink_n_next = sink_n_reg;
      if (bus_valid_i) begin
         cmd_next = bus_icons_i;
         sink_n_next = ~bus_sink_i; // low sinks, high releases
      end
   end

   // =====================================================
   // display sequencer: flash, bulb check, run, chase
   always_comb begin
      state_next = state_reg;
      tmr_next = tmr_reg;
      flash_next = flash_reg;
      chase_next = chase_reg;
      ign_seen_next = ign_seen_reg | ign_sync;
      // loss timer restarts on any bus word
      if (bus_valid_i) begin
         loss_next = '0;
      end else if (loss_reg != LOSS_LIM) begin
         loss_next = loss_reg + TMR_W'(1);
      end else begin
         loss_next = loss_reg;
      end
      case (state_reg)
         ST_FLASH: begin
            // self-test waits for ignition, key-off keeps only wired lamps
            if (ign_seen_reg) begin
               if (tmr_reg == FLASH_LIM) begin
                  tmr_next = '0;
                  flash_next = flash_reg + 4'h1;
                  if (flash_reg == FLASH_EDGES) begin
                     state_next = ST_CHECK;
                  end
               end else begin
                  tmr_next = tmr_reg + TMR_W'(1);
               end
            end
         end
         ST_CHECK: begin
            if (tmr_reg == CHECK_LIM) begin
               tmr_next = '0;
               state_next = ST_RUN;
            end else begin
               tmr_next = tmr_reg + TMR_W'(1);
            end
         end
         ST_RUN: begin
            if (loss_reg == LOSS_LIM && !bus_valid_i) begin
               state_next = ST_CHASE;
               tmr_next = '0;
               chase_next = '0;
            end
         end
         ST_CHASE: begin
            if (bus_valid_i) begin
               state_next = ST_RUN;
            end else if (tmr_reg == STEP_LIM) begin
               tmr_next = '0;
               chase_next = (chase_reg == ICON_IDX_W'(ICON_CNT - 1)) ? '0 :
                            chase_reg + ICON_IDX_W'(1);
            end else begin
               tmr_next = tmr_reg + TMR_W'(1);
            end
         end
         default: begin
            state_next = ST_FLASH;
         end
      endcase
   end

   // =====================================================
   // icon mux; wired lamps override every mode
   always_comb begin
      case (state_reg)
         ST_FLASH: base = (ign_seen_reg && !flash_reg[0]) ? '1 : '0;
         ST_CHECK: base = '1;
         ST_RUN: base = cmd_reg;
         ST_CHASE: base = ICON_CNT'(1) << chase_reg;
         default: base = '0;
      endcase
      icon_next = base;
      icon_next[ICON_LEFT_TURN] = lamp_sync[0];
      icon_next[ICON_RIGHT_TURN] = lamp_sync[1];
      icon_next[ICON_HIGH_BEAM] = lamp_sync[2];
   end

   // =====================================================
   // state registers, all frozen while ce_i is low
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_reg <= ST_FLASH;
         tmr_reg <= '0;
         loss_reg <= '0;
         flash_reg <= '0;
         chase_reg <= '0;
         cmd_reg <= ICON_RST;
         sink_n_reg <= SINK_N_RST;
         icon_reg <= ICON_RST;
         ign_seen_reg <= 1'b0;
      end else if (ce_i) begin
         state_reg <= state_next;
         tmr_reg <= tmr_next;
         loss_reg <= loss_next;
         flash_reg <= flash_next;
         chase_reg <= chase_next;
         cmd_reg <= cmd_next;
         sink_n_reg <= sink_n_next;
         icon_reg <= icon_next;
         ign_seen_reg <= ign_seen_next;
      end
   end

   // chase flag taken from next state so it rises with the chase mux
   logic lost_reg;
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         lost_reg <= 1'b0;
      end else if (ce_i) begin
         lost_reg <= (state_next == ST_CHASE);
      end
   end

   assign icon_o = icon_reg;
   assign sink_n_o = sink_n_reg;
   assign comm_lost_o = lost_reg;

   // =====================================================
   // assertions
   AST_SINK_CMD: assert property (
      @(posedge core_clk_i) disable iff (!nrst_i)
      ce_i && bus_valid_i |=> sink_n_o == ~$past(bus_sink_i))
      else $error("sink outputs do not follow bus command");
   AST_SINK_HOLD: assert property (
      @(posedge core_clk_i) disable iff (!nrst_i)
      !bus_valid_i |=> $stable(sink_n_o))
      else $error("sink outputs changed without a bus command");
   AST_RUN_ICONS: assert property (
      @(posedge core_clk_i) disable iff (!nrst_i)
      ce_i && state_reg == ST_RUN |=>
      icon_o[ICON_CNT-1:3] == $past(cmd_reg[ICON_CNT-1:3]))
      else $error("run icons differ from bus command");
   AST_LAMP_FOLLOW: assert property (
      @(posedge core_clk_i) disable iff (!nrst_i)
      ce_i |=> icon_o[2:0] == $past(lamp_sync))
      else $error("wired lamp icon not following input");
   // flag and state rise on the same edge; a word right after may end chase
   AST_CHASE_ENTRY: assert property (
      @(posedge core_clk_i) disable iff (!nrst_i)
      ce_i && state_reg == ST_RUN && loss_reg == LOSS_LIM && !bus_valid_i
      |=> state_reg == ST_CHASE && comm_lost_o)
      else $error("chase not entered on bus loss");
   AST_CHASE_EXIT: assert property (
      @(posedge core_clk_i) disable iff (!nrst_i)
      ce_i && state_reg == ST_CHASE && bus_valid_i
      |=> state_reg == ST_RUN && loss_reg == '0)
      else $error("chase not left on fresh bus data");
   // icon reg is frozen with ce_i low, so only judge after an enabled edge
   AST_CHECK_ALL_ON: assert property (
      @(posedge core_clk_i) disable iff (!nrst_i)
      $past(ce_i) && state_reg == ST_CHECK && $past(state_reg == ST_CHECK)
      |-> icon_o[ICON_CNT-1:3] == '1)
      else $error("bulb check icons not all lit");
   AST_FLASH_FIRST: assert property (
      @(posedge core_clk_i) disable iff (!nrst_i)
      state_reg == ST_CHECK && $past(state_reg) == ST_FLASH
      |-> $past(flash_reg) == FLASH_EDGES && $past(ign_seen_reg))
      else $error("bulb check entered without full self-test flash");

   COV_CHECK: cover property (@(posedge core_clk_i) state_reg == ST_CHECK);
   COV_RUN: cover property (@(posedge core_clk_i) state_reg == ST_RUN);
   COV_CHASE: cover property (@(posedge core_clk_i) comm_lost_o);
   COV_RECOVER: cover property (@(posedge core_clk_i)
      state_reg == ST_CHASE ##1 state_reg == ST_RUN);
endmodule

/* File: bench/aic_dc_model.sv */
// aic_dc_model: behavioural central_data_computer driving decoded bus words
// assumes bench requests arrive by non-blocking assignment on core_clk_i
`timescale 1ns/1ps
module aic_dc_model
   import aic_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic nrst_i,
   input wire logic req_i,
   input wire logic [aic_pkg::ICON_CNT-1:0] req_icons_i,
   input wire logic [aic_pkg::SINK_CNT-1:0] req_sink_i,
   output logic bus_valid_o,
   output logic [aic_pkg::ICON_CNT-1:0] bus_icons_o,
   output logic [aic_pkg::SINK_CNT-1:0] bus_sink_o
);
   // =====================================================
   // word launch
   // one word per request cycle; idle data toggles so a late sample
   // by the receiver never passes for the word just sent
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         bus_valid_o <= 1'b0;
         bus_icons_o <= '0;
         bus_sink_o <= '0;
      end else if (req_i) begin
         bus_valid_o <= 1'b1;
         bus_icons_o <= req_icons_i;
         bus_sink_o <= req_sink_i;
      end else begin
         bus_valid_o <= 1'b0;
         bus_icons_o <= ~bus_icons_o;
         bus_sink_o <= ~bus_sink_o;
      end
   end
endmodule

/* File: bench/aic_top_tb.sv */
// aic_top_tb: self-checking bench for the annunciator icon controller
// assumes shortened loss, check, flash and chase step counts
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
   begin \
      check_count++; \
      if ((got) !== (exp)) begin \
         mismatches++; \
         $display("MISMATCH %s expected %h seen %h", nm, exp, got); \
      end \
   end
module aic_top_tb;
   import aic_pkg::*;
   typedef struct {logic [1:0] sink; logic [2:0] pins; logic [1:0] exp_sn;} aic_row_t;
   logic core_clk_i, nrst_i, ce_i, req, bus_valid, ignition;
   logic left_turn, right_turn, high_beam, comm_lost;
   logic [ICON_CNT-1:0] req_icons, bus_icons, icon;
   logic [SINK_CNT-1:0] req_sink, bus_sink, sink_n;
   int mismatches, check_count;
   aic_row_t rows[6] = '{'{2'h0, 3'h0, 2'h3}, '{2'h1, 3'h1, 2'h2}, '{2'h2, 3'h2, 2'h1},
      '{2'h3, 3'h4, 2'h0}, '{2'h0, 3'h7, 2'h3}, '{2'h2, 3'h5, 2'h1}};
   // =====================================================
   // design and far side
   aic_top #(.LOSS_CYCLES(200), .CHECK_CYCLES(50), .FLASH_CYCLES(4), .STEP_CYCLES(3))
      dut_u (.core_clk_i(core_clk_i),
      .nrst_i(nrst_i), .ce_i(ce_i), .bus_valid_i(bus_valid), .bus_icons_i(bus_icons),
      .bus_sink_i(bus_sink), .left_turn_i(left_turn), .right_turn_i(right_turn),
      .high_beam_i(high_beam), .ignition_i(ignition), .icon_o(icon), .sink_n_o(sink_n),
      .comm_lost_o(comm_lost));
   aic_dc_model dc_u (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .req_i(req),
      .req_icons_i(req_icons), .req_sink_i(req_sink), .bus_valid_o(bus_valid),
      .bus_icons_o(bus_icons), .bus_sink_o(bus_sink));
   // =====================================================
   // clock and watchdog
   initial begin
      core_clk_i = 1'b0;
      forever #50 core_clk_i = ~core_clk_i;
   end
   // whole run is a few hundred cycles; this is far beyond it
   initial begin
      repeat (5000) @(posedge core_clk_i);
      mismatches++;
      end_sim();
   end
   // =====================================================
   // helpers
   // one word plus new pin levels; returns just after the taking edge
   task automatic send_word(input logic [23:0] ic, input logic [1:0] sk, input logic [2:0] p);
      @(posedge core_clk_i);
      req <= 1'b1;
      req_icons <= ic;
      req_sink <= sk;
      {high_beam, right_turn, left_turn} <= p;
      @(posedge core_clk_i);
      req <= 1'b0;
      @(posedge core_clk_i);
      #1;
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // =====================================================
   // main sequence
   initial begin
      {nrst_i, req, ignition, left_turn, right_turn, high_beam} = '0;
      ce_i = 1'b1;
      req_icons = '0;
      req_sink = '0;
      repeat (2) @(posedge core_clk_i);
      #1;
      `CHK("reset icons", 24'h000000, icon);
      `CHK("reset sinks", 2'h3, sink_n);
      `CHK("reset lost", 1'b0, comm_lost);
      repeat (2) @(posedge core_clk_i);
      nrst_i <= 1'b1;
      $display("reset test done");
      // table rows: sink command and wired lamps, key off
      foreach (rows[i]) begin
         send_word(24'h5a5a5a ^ 24'(i), rows[i].sink, rows[i].pins);
         `CHK("sink_n", rows[i].exp_sn, sink_n);
         @(posedge core_clk_i);
         #1;
         `CHK("wired icons", rows[i].pins, icon[2:0]);
         `CHK("sink held", rows[i].exp_sn, sink_n);
         $display("row %0d done", i);
      end
      // frozen clock enable: word is never taken
      @(posedge core_clk_i);
      ce_i <= 1'b0;
      send_word(24'h000000, 2'h3, 3'h0);
      `CHK("sink frozen", 2'h1, sink_n);
      @(posedge core_clk_i);
      ce_i <= 1'b1;
      $display("enable test done");
      // back-to-back words
      @(posedge core_clk_i);
      req <= 1'b1;
      req_sink <= 2'h1;
      @(posedge core_clk_i);
      req_sink <= 2'h2;
      @(posedge core_clk_i);
      req <= 1'b0;
      #1;
      `CHK("first word", 2'h2, sink_n);
      @(posedge core_clk_i);
      #1;
      `CHK("second word", 2'h1, sink_n);
      $display("back to back test done");
      // reset in mid-run must act at once, lamp pin high
      @(posedge core_clk_i);
      high_beam <= 1'b1;
      repeat (3) @(posedge core_clk_i);
      nrst_i <= 1'b0;
      #1;
      `CHK("async icons", 24'h000000, icon);
      `CHK("async sinks", 2'h3, sink_n);
      repeat (3) @(posedge core_clk_i);
      nrst_i <= 1'b1;
      ignition <= 1'b1;
      // bus word during the self-test flash is stored, not shown
      // ignition seen on the edge that takes this word; call it s
      send_word(24'h000000, 2'h1, 3'h4);
      repeat (2) @(posedge core_clk_i);
      #1;
      `CHK("flash on", 21'h1fffff, icon[23:3]);
      `CHK("flash lamps", 3'h4, icon[2:0]);
      `CHK("flash sinks", 2'h2, sink_n);
      `CHK("no loss yet", 1'b0, comm_lost);
      repeat (4) @(posedge core_clk_i);
      #1;
      `CHK("flash off", 21'h000000, icon[23:3]);
      $display("self-test test done");
      // twelve half periods of four edges end at s+48; icons 3 to 23 on from s+49
      repeat (43) @(posedge core_clk_i);
      #1;
      `CHK("check on", 21'h1fffff, icon[23:3]);
      // word taken at s+52 is stored but hidden until run at s+98
      send_word(24'hc3a5f0, 2'h2, 3'h1);
      `CHK("check sinks", 2'h1, sink_n);
      repeat (45) @(posedge core_clk_i);
      #1;
      `CHK("check held", 24'hfffff9, icon);
      repeat (2) @(posedge core_clk_i);
      #1;
      `CHK("run icons", 24'hc3a5f1, icon);
      $display("bulb check test done");
      // 200 quiet edges after s+52: chase at s+252, stepping every 3 edges
      repeat (152) @(posedge core_clk_i);
      #1;
      `CHK("not lost yet", 1'b0, comm_lost);
      @(posedge core_clk_i);
      #1;
      `CHK("lost", 1'b1, comm_lost);
      repeat (10) @(posedge core_clk_i);
      #1;
      `CHK("chase step 3", 24'h000009, icon);
      repeat (3) @(posedge core_clk_i);
      #1;
      `CHK("chase step 4", 24'h000011, icon);
      $display("chase test done");
      // fresh word at s+268 ends chase and restarts the loss timer
      send_word(24'h0f0f00, 2'h0, 3'h0);
      `CHK("recovered", 1'b0, comm_lost);
      `CHK("recover sinks", 2'h3, sink_n);
      @(posedge core_clk_i);
      #1;
      `CHK("recover icons", 24'h0f0f00, icon);
      repeat (198) @(posedge core_clk_i);
      #1;
      `CHK("timer restarted", 1'b0, comm_lost);
      @(posedge core_clk_i);
      #1;
      `CHK("lost again", 1'b1, comm_lost);
      $display("recovery test done");
      end_sim();
   end
endmodule
